/* design/aspic_pkg.sv */
// shared constants and types of the serial port command interface
package aspic_pkg;

    localparam logic [5:0]  DEV_ADDR        = 6'h04;
    localparam int          DATA_W          = 8;
    localparam int          FIFO_DEPTH      = 8;
    localparam int          NUM_PORTS       = 4;

    // command kinds carried in paddr[13:12]
    localparam logic [1:0]  KIND_CONTROL    = 2'h0;
    localparam logic [1:0]  KIND_SKIP       = 2'h1;
    localparam logic [1:0]  KIND_INPUT      = 2'h2;
    localparam logic [1:0]  KIND_OUTPUT     = 2'h3;
    localparam int          KIND_LSB        = 12;
    localparam int          FUNC_LSB        = 8;
    localparam int          DEV_LSB         = 2;

    // function codes
    localparam logic [3:0]  FN_00           = 4'h0;
    localparam logic [3:0]  FN_01           = 4'h1;
    localparam logic [3:0]  FN_02           = 4'h2;
    localparam logic [3:0]  FN_04           = 4'h4;
    localparam logic [3:0]  FN_05           = 4'h5;
    localparam logic [3:0]  FN_06           = 4'h6;
    localparam logic [3:0]  FN_07           = 4'h7;
    localparam logic [3:0]  FN_10           = 4'h8;
    localparam logic [3:0]  FN_11           = 4'h9;
    localparam logic [3:0]  FN_12           = 4'hA;
    localparam logic [3:0]  FN_14           = 4'hC;
    localparam logic [3:0]  FN_15           = 4'hD;
    localparam logic [3:0]  FN_16           = 4'hE;
    localparam logic [3:0]  FN_17           = 4'hF;

    // control word one: port select and bit period minus one in pclk cycles
    localparam int          C1_PORT_LSB     = 14;
    localparam int          C1_DIV_W        = 14;
    // control word two flags
    localparam int          C2_TWO_STOP     = 0;
    localparam int          C2_DMA_EN       = 1;
    localparam int          C2_VECTORED     = 2;

    localparam logic [15:0] CTRL_RESET      = 16'h0000;
    localparam logic [13:0] DIV_MIN         = 14'h0002;
    localparam logic [31:0] DELIVERED_BIT   = 32'h8000_0000;
    localparam logic [15:0] DEVICE_ID       = 16'h00A5; // arbitrary value

    typedef struct packed {
        logic [1:0] kind;
        logic [3:0] func;
        logic [5:0] dev;
    } aspic_cmd_type;

    typedef struct packed {
        logic             req;
        logic [DATA_W-1:0] data;
    } aspic_dma_type;

endpackage : aspic_pkg

/* design/aspic_top.sv */
// command decode, serial engines, dma and transmit fifo
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
module aspic_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem [D];
    logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [AW:0]   cnt_r, cnt_nxt;
    logic          push, pop;

    always_comb begin
        push      = in_valid && in_ready;
        pop       = out_valid && out_ready;
        in_ready  = cnt_r != (AW+1)'(D);
        out_valid = cnt_r != '0;
        out_data  = mem[rp_r];
        wp_nxt    = push ? (wp_r == AW'(D-1) ? '0 : wp_r + 1'b1) : wp_r;
        rp_nxt    = pop ? (rp_r == AW'(D-1) ? '0 : rp_r + 1'b1) : rp_r;
        cnt_nxt   = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else if (ce) begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    always_ff @(posedge pclk) begin
        if (ce && push) begin
            mem[wp_r] <= in_data;
        end
    end
endmodule : aspic_fifo

////////////////////////////////////////////////////////////////////////////
// Behaviour
// - respond only to commands addressed to device 04
// - skip 00 on either side ready, 06 tx can accept, 07 rx waiting
// - skip 01 whenever the interface is not busy
// - skip 02 rx quiet, 04 both quiet, 05 tx quiet
// - control 02/04 enable/disable rx irq, 05 enables tx irq
// - standard or vectored mode with separate rx and tx vectors
// - interrupt when tx can take a character or rx holds one
// - enabled dma channel requests a cycle whenever a character can move and its count is not zero
// - channel end of range raises an interrupt
// - tx and rx each own an independent dma channel
// - input 00 and 10 both deliver only when ready, then clear ready
// - input 04 returns rx word one, 06 returns tx word one
// - up to four serial ports, each one terminal
module aspic_top
    import aspic_pkg::*;
(
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  ce,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [15:0]           paddr,
    input  wire logic [31:0]           pwdata,
    output logic      [31:0]           prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic [NUM_PORTS-1:0]  rx_line,
    output logic      [NUM_PORTS-1:0]  tx_line,
    output logic                       irq_req,
    output logic      [15:0]           irq_vector,
    input  wire logic                  irq_clear_active,
    output aspic_dma_type              dma_rx,
    input  wire logic                  dma_rx_ack,
    output logic                       dma_tx_req,
    input  wire logic                  dma_tx_ack,
    input  wire logic [DATA_W-1:0]     dma_tx_data
);
    typedef enum logic [1:0] {TX_IDLE, TX_SHIFT} aspic_tx_type;
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA} aspic_rx_type;

    function automatic aspic_cmd_type aspic_decode(input logic [15:0] a);
        aspic_decode.kind = a[KIND_LSB +: 2];
        aspic_decode.func = a[FUNC_LSB +: 4];
        aspic_decode.dev  = a[DEV_LSB +: 6];
    endfunction : aspic_decode

    function automatic logic [1:0] aspic_port(input logic [15:0] c1);
        aspic_port = c1[C1_PORT_LSB +: 2];
    endfunction : aspic_port

    ////////////////////////////////////////////////////////////////////////
    // command registers
    aspic_cmd_type cmd;
    logic [15:0] rc1_r, rc1_nxt, tc1_r, tc1_nxt, rc2_r, rc2_nxt;
    logic [15:0] tc2_r, tc2_nxt, rvec_r, rvec_nxt, tvec_r, tvec_nxt;
    logic [15:0] rcnt_r, rcnt_nxt, tcnt_r, tcnt_nxt;
    logic        rx_ie_r, rx_ie_nxt, tx_ie_r, tx_ie_nxt;
    logic        echo_r, echo_nxt, active_r, active_nxt;
    logic        reor_r, reor_nxt, teor_r, teor_nxt;
    logic        rxrdy_r, rxrdy_nxt, irq_r, irq_nxt;
    logic [15:0] vec_r, vec_nxt;
    logic [7:0]  rxbuf_r, rxbuf_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        pready_r, pready_nxt, perr_r, perr_nxt;
    logic        dtx_r, dtx_nxt;
    aspic_dma_type drx_r, drx_nxt;
    logic        take, hit, init, rx_done, tx_busy, rx_busy;
    logic        tx_ok, rx_irq, tx_irq, apb_push, dma_push, echo_push;
    logic        f_in_valid, f_in_ready, f_out_valid, f_out_ready;
    logic [7:0]  f_in_data, f_out_data, rx_char;

    always_comb begin
        cmd        = aspic_decode(paddr);
        take       = psel && penable && pready_r;
        hit        = cmd.dev == DEV_ADDR;
        init       = take && hit && pwrite && cmd.kind == KIND_CONTROL
                     && cmd.func == FN_17;
        tx_ok      = f_in_ready;
        rx_irq     = (rx_ie_r && rxrdy_r) || reor_r;
        tx_irq     = (tx_ie_r && tx_ok) || teor_r;
        apb_push   = take && hit && pwrite && cmd.kind == KIND_OUTPUT
                     && cmd.func == FN_00 && tx_ok && !tc2_r[C2_DMA_EN];
        dma_push   = dtx_r && dma_tx_ack && !apb_push;
        echo_push  = echo_r && rx_done && !apb_push && !dma_push;
        f_in_valid = apb_push || dma_push || echo_push;
        f_in_data  = apb_push ? pwdata[7:0]
                   : (dma_push ? dma_tx_data : rx_char);
        pready_nxt = psel && penable && !pready_r;
        perr_nxt   = 1'b0;
        rdata_nxt  = rdata_r;
        rc1_nxt = rc1_r; tc1_nxt = tc1_r; rc2_nxt = rc2_r; tc2_nxt = tc2_r;
        rvec_nxt = rvec_r; tvec_nxt = tvec_r;
        rcnt_nxt = rcnt_r; tcnt_nxt = tcnt_r;
        rx_ie_nxt = rx_ie_r; tx_ie_nxt = tx_ie_r; echo_nxt = echo_r;
        reor_nxt = reor_r; teor_nxt = teor_r;
        rxbuf_nxt = rxbuf_r;
        rxrdy_nxt = rxrdy_r;
        if (psel && penable && !pready_r) begin
            perr_nxt  = !hit || (pwrite != (cmd.kind == KIND_CONTROL
                                 || cmd.kind == KIND_OUTPUT));
            rdata_nxt = '0;
            if (hit && !pwrite && cmd.kind == KIND_SKIP) begin
                case (cmd.func)
                    FN_00:   rdata_nxt[0] = rxrdy_r || tx_ok;
                    FN_01:   rdata_nxt[0] = !(tx_busy || rx_busy
                                              || f_out_valid);
                    FN_02:   rdata_nxt[0] = !rx_irq;
                    FN_04:   rdata_nxt[0] = !rx_irq && !tx_irq;
                    FN_05:   rdata_nxt[0] = !tx_irq;
                    FN_06:   rdata_nxt[0] = tx_ok;
                    FN_07:   rdata_nxt[0] = rxrdy_r;
                    default: rdata_nxt[0] = 1'b0;
                endcase
            end else if (hit && !pwrite && cmd.kind == KIND_INPUT) begin
                case (cmd.func)
                    FN_00, FN_10: begin
                        if (rxrdy_r) begin
                            rdata_nxt = DELIVERED_BIT | 32'(rxbuf_r);
                        end
                    end
                    FN_04:   rdata_nxt = 32'(rc1_r);
                    FN_05:   rdata_nxt = 32'(rc2_r);
                    FN_06:   rdata_nxt = 32'(tc1_r);
                    FN_07:   rdata_nxt = 32'(tc2_r);
                    FN_11:   rdata_nxt = 32'(DEVICE_ID);
                    FN_14:   rdata_nxt = 32'(rcnt_r);
                    FN_15:   rdata_nxt = 32'(tcnt_r);
                    FN_16:   rdata_nxt = 32'(rvec_r);
                    FN_17:   rdata_nxt = 32'(tvec_r);
                    default: rdata_nxt = '0;
                endcase
            end
        end
        if (take && hit && !pwrite && cmd.kind == KIND_INPUT
            && (cmd.func == FN_00 || cmd.func == FN_10)) begin
            rxrdy_nxt = 1'b0;
        end
        if (drx_r.req && dma_rx_ack) begin
            rxrdy_nxt = 1'b0;
            rcnt_nxt  = rcnt_r - 16'h0001;
            if (rcnt_r == 16'h0001) begin
                reor_nxt = 1'b1;
            end
        end
        if (dma_push) begin
            tcnt_nxt = tcnt_r - 16'h0001;
            if (tcnt_r == 16'h0001) begin
                teor_nxt = 1'b1;
            end
        end
        if (take && hit && pwrite && cmd.kind == KIND_CONTROL) begin
            case (cmd.func)
                FN_02:   rx_ie_nxt = 1'b1;
                FN_04:   rx_ie_nxt = 1'b0;
                FN_05:   tx_ie_nxt = 1'b1;
                FN_07:   tx_ie_nxt = 1'b0;
                FN_12:   echo_nxt  = 1'b1;
                default: echo_nxt  = echo_r;
            endcase
        end
        if (take && hit && pwrite && cmd.kind == KIND_OUTPUT) begin
            case (cmd.func)
                FN_04:   rc1_nxt = pwdata[15:0];
                FN_05:   rc2_nxt = pwdata[15:0];
                FN_06:   tc1_nxt = pwdata[15:0];
                FN_07:   tc2_nxt = pwdata[15:0];
                FN_14: begin
                    rcnt_nxt = pwdata[15:0];
                    reor_nxt = 1'b0;
                end
                FN_15: begin
                    tcnt_nxt = pwdata[15:0];
                    teor_nxt = 1'b0;
                end
                FN_16:   rvec_nxt = pwdata[15:0];
                FN_17:   tvec_nxt = pwdata[15:0];
                default: rvec_nxt = rvec_r;
            endcase
        end
        if (init) begin
            rx_ie_nxt = 1'b0;
            tx_ie_nxt = 1'b0;
            echo_nxt  = 1'b0;
            reor_nxt  = 1'b0;
            teor_nxt  = 1'b0;
            rxrdy_nxt = 1'b0;
        end
        if (rx_done) begin
            rxbuf_nxt = rx_char;
            rxrdy_nxt = 1'b1;
        end
        drx_nxt.req  = rc2_r[C2_DMA_EN] && rxrdy_nxt
                       && rcnt_nxt != 16'h0000;
        drx_nxt.data = rxbuf_nxt;
        dtx_nxt      = tc2_r[C2_DMA_EN] && f_in_ready && !dma_push
                       && tcnt_r != 16'h0000 && !init;
        active_nxt   = active_r;
        if (irq_r && rc2_r[C2_VECTORED]) begin
            active_nxt = 1'b1;
        end
        if (irq_clear_active || init) begin
            active_nxt = 1'b0;
        end
        irq_nxt = (rx_irq || tx_irq) && !active_nxt && !init;
        vec_nxt = rc2_r[C2_VECTORED] ? (rx_irq ? rvec_r : tvec_r)
                                     : 16'h0000;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc1_r <= CTRL_RESET; tc1_r <= CTRL_RESET;
            rc2_r <= CTRL_RESET; tc2_r <= CTRL_RESET;
            rvec_r <= CTRL_RESET; tvec_r <= CTRL_RESET;
            rcnt_r <= CTRL_RESET; tcnt_r <= CTRL_RESET;
            rx_ie_r <= 1'b0; tx_ie_r <= 1'b0; echo_r <= 1'b0;
            reor_r <= 1'b0; teor_r <= 1'b0; rxrdy_r <= 1'b0;
            active_r <= 1'b0; irq_r <= 1'b0; vec_r <= '0;
            rxbuf_r <= '0; rdata_r <= '0; pready_r <= 1'b0;
            perr_r <= 1'b0; dtx_r <= 1'b0; drx_r <= '0;
        end else if (ce) begin
            rc1_r <= rc1_nxt; tc1_r <= tc1_nxt;
            rc2_r <= rc2_nxt; tc2_r <= tc2_nxt;
            rvec_r <= rvec_nxt; tvec_r <= tvec_nxt;
            rcnt_r <= rcnt_nxt; tcnt_r <= tcnt_nxt;
            rx_ie_r <= rx_ie_nxt; tx_ie_r <= tx_ie_nxt; echo_r <= echo_nxt;
            reor_r <= reor_nxt; teor_r <= teor_nxt; rxrdy_r <= rxrdy_nxt;
            active_r <= active_nxt; irq_r <= irq_nxt; vec_r <= vec_nxt;
            rxbuf_r <= rxbuf_nxt; rdata_r <= rdata_nxt;
            pready_r <= pready_nxt; perr_r <= perr_nxt;
            dtx_r <= dtx_nxt; drx_r <= drx_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // transmit fifo
    aspic_fifo #(.W(DATA_W), .D(FIFO_DEPTH)) u_txf (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .in_valid  (f_in_valid),
        .in_ready  (f_in_ready),
        .in_data   (f_in_data),
        .out_valid (f_out_valid),
        .out_ready (f_out_ready),
        .out_data  (f_out_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // transmitter
    aspic_tx_type        txs_r, txs_nxt;
    logic [11:0]         tsh_r, tsh_nxt;
    logic [3:0]          tbits_r, tbits_nxt;
    logic [13:0]         tdiv_r, tdiv_nxt;
    logic [NUM_PORTS-1:0] txl_r, txl_nxt;

    always_comb begin
        txs_nxt     = txs_r;
        tsh_nxt     = tsh_r;
        tbits_nxt   = tbits_r;
        tdiv_nxt    = tdiv_r;
        f_out_ready = 1'b0;
        tx_busy     = txs_r != TX_IDLE;
        case (txs_r)
            TX_IDLE: begin
                if (f_out_valid && !init) begin
                    f_out_ready = 1'b1;
                    tsh_nxt     = {2'b11, f_out_data, 1'b0, 1'b1};
                    tbits_nxt   = tc2_r[C2_TWO_STOP] ? 4'hB : 4'hA;
                    tdiv_nxt    = '0;
                    txs_nxt     = TX_SHIFT;
                end
            end
            TX_SHIFT: begin
                if (tdiv_r == '0) begin
                    tsh_nxt   = {1'b1, tsh_r[11:1]};
                    tbits_nxt = tbits_r - 4'h1;
                    tdiv_nxt  = tc1_r[C1_DIV_W-1:0] < DIV_MIN ? DIV_MIN
                                : tc1_r[C1_DIV_W-1:0];
                    if (tbits_r == 4'h0) begin
                        txs_nxt = TX_IDLE;
                    end
                end else begin
                    tdiv_nxt = tdiv_r - 14'h0001;
                end
                if (init) begin
                    txs_nxt = TX_IDLE;
                    tsh_nxt = '1;
                end
            end
            default: txs_nxt = TX_IDLE;
        endcase
        for (int p = 0; p < NUM_PORTS; p++) begin
            txl_nxt[p] = (echo_r ? aspic_port(rc1_r) : aspic_port(tc1_r))
                         == 2'(p) ? tsh_nxt[0] : 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txs_r   <= TX_IDLE;
            tsh_r   <= '1;
            tbits_r <= '0;
            tdiv_r  <= '0;
            txl_r   <= '1;
        end else if (ce) begin
            txs_r   <= txs_nxt;
            tsh_r   <= tsh_nxt;
            tbits_r <= tbits_nxt;
            tdiv_r  <= tdiv_nxt;
            txl_r   <= txl_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // receiver
    aspic_rx_type rxs_r, rxs_nxt;
    logic [7:0]   rsh_r, rsh_nxt;
    logic [3:0]   rbits_r, rbits_nxt;
    logic [13:0]  rdiv_r, rdiv_nxt, rper;
    logic         rin;

    always_comb begin
        rin       = rx_line[aspic_port(rc1_r)];
        rper      = rc1_r[C1_DIV_W-1:0] < DIV_MIN ? DIV_MIN
                    : rc1_r[C1_DIV_W-1:0];
        rxs_nxt   = rxs_r;
        rsh_nxt   = rsh_r;
        rbits_nxt = rbits_r;
        rdiv_nxt  = rdiv_r;
        rx_done   = 1'b0;
        rx_char   = rsh_r;
        rx_busy   = rxs_r != RX_IDLE;
        case (rxs_r)
            RX_IDLE: begin
                if (!rin) begin
                    rdiv_nxt = {1'b0, rper[13:1]};
                    rxs_nxt  = RX_START;
                end
            end
            RX_START: begin
                if (rdiv_r != '0) begin
                    rdiv_nxt = rdiv_r - 14'h0001;
                end else if (rin) begin
                    rxs_nxt = RX_IDLE;
                end else begin
                    rdiv_nxt  = rper;
                    rbits_nxt = 4'h8;
                    rxs_nxt   = RX_DATA;
                end
            end
            RX_DATA: begin
                if (rdiv_r != '0) begin
                    rdiv_nxt = rdiv_r - 14'h0001;
                end else if (rbits_r == 4'h0) begin
                    rx_done = rin;
                    rxs_nxt = RX_IDLE;
                end else begin
                    rsh_nxt   = {rin, rsh_r[7:1]};
                    rbits_nxt = rbits_r - 4'h1;
                    rdiv_nxt  = rper;
                end
            end
            default: rxs_nxt = RX_IDLE;
        endcase
        if (init) begin
            rxs_nxt = RX_IDLE;
            rx_done = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rxs_r   <= RX_IDLE;
            rsh_r   <= '0;
            rbits_r <= '0;
            rdiv_r  <= '0;
        end else if (ce) begin
            rxs_r   <= rxs_nxt;
            rsh_r   <= rsh_nxt;
            rbits_r <= rbits_nxt;
            rdiv_r  <= rdiv_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    always_comb begin
        prdata     = rdata_r;
        pready     = pready_r;
        pslverr    = perr_r;
        tx_line    = txl_r;
        irq_req    = irq_r;
        irq_vector = vec_r;
        dma_rx     = drx_r;
        dma_tx_req = dtx_r;
    end
endmodule : aspic_top

/* tb/aspic_bench.sv */
// self-checking bench for the serial port command block
`timescale 1ns/1ps
module aspic_bench
    import aspic_pkg::*;
;
    logic          pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [15:0]   paddr = 16'h0000;
    logic [31:0]   pwdata = 32'h0, prdata, rd;
    logic          pready, pslverr, irq_req, er, dma_rx_ack = 0, ica = 0;
    logic          ce = 1;
    logic [15:0]   ivec;
    logic [3:0]    rx_line, tx_line;
    aspic_dma_type dma_rx;
    int            n_mismatch = 0, num_checks = 0;
    logic [3:0]    sf [6] = '{FN_00, FN_06, FN_07, FN_02, FN_04, FN_05};
    logic          se [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1};
    always #2.5 pclk = ~pclk;
    aspic_top u_dut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_line(rx_line), .tx_line(tx_line), .irq_req(irq_req),
        .irq_vector(ivec), .irq_clear_active(ica), .dma_rx(dma_rx),
        .dma_rx_ack(dma_rx_ack), .dma_tx_req(), .dma_tx_ack(1'b0),
        .dma_tx_data(8'h00));
    aspic_term u_term (.pclk(pclk), .tx_line(tx_line),
        .rx_line(rx_line));
    ////////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic guard(input int i, input int lim);
        if (i >= lim) begin
            n_mismatch++;
            end_of_test();
        end
    endtask : guard
    task automatic bus(input logic w, input logic [1:0] k, input logic [3:0] f,
                       input logic [31:0] d, input logic [5:0] dv = DEV_ADDR);
        int i;
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= {2'b00, k, f, dv, 2'b00};
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 20 && pready !== 1'b1; i++) @(posedge pclk);
        guard(i, 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : bus
    task automatic wait_skip(input logic [3:0] f);
        int i;
        for (i = 0; i < 200; i++) begin
            bus(1'b0, KIND_SKIP, f, 0);
            if (rd[0] === 1'b1) break;
        end
        guard(i, 200);
    endtask : wait_skip
    task automatic wait_tx(input int n);
        int i;
        for (i = 0; i < 800 && u_term.n_got < n; i++) @(posedge pclk);
        guard(i, 800);
    endtask : wait_tx
    ////////////////////////////////////////////////////////////////////////
    initial begin
        int i;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        check(tx_line, 4'hF);
        bus(1'b0, KIND_SKIP, FN_01, 0, 6'h05);
        check(er, 1'b1);
        bus(1'b0, KIND_SKIP, FN_01, 0);
        check(rd, 32'h1);
        bus(1'b1, KIND_OUTPUT, FN_04, 32'h8004);
        bus(1'b1, KIND_OUTPUT, FN_06, 32'h8004);
        bus(1'b0, KIND_INPUT, FN_06, 0);
        check(rd, 32'h8004);
        foreach (sf[j]) begin
            bus(1'b0, KIND_SKIP, sf[j], 0);
            check(rd, se[j]);
        end
        bus(1'b1, KIND_CONTROL, FN_02, 0);
        u_term.send(8'h5A);
        wait_skip(FN_07);
        check(irq_req, 1'b1);
        check(ivec, 32'h0);
        bus(1'b0, KIND_INPUT, FN_10, 0);
        check(rd, DELIVERED_BIT | 32'h5A);
        bus(1'b1, KIND_CONTROL, FN_04, 0);
        u_term.send(8'hA5);
        wait_skip(FN_07);
        check(irq_req, 1'b0);
        bus(1'b0, KIND_INPUT, FN_00, 0);
        check(rd, DELIVERED_BIT | 32'hA5);
        bus(1'b1, KIND_OUTPUT, FN_00, 32'hC3);
        wait_tx(1);
        check(u_term.got, 8'hC3);
        bus(1'b1, KIND_CONTROL, FN_12, 0);
        u_term.send(8'h3C);
        wait_tx(2);
        check(u_term.got, 8'h3C);
        bus(1'b1, KIND_CONTROL, FN_05, 0);
        bus(1'b0, KIND_SKIP, FN_05, 0);
        check(rd, 32'h0);
        bus(1'b1, KIND_CONTROL, FN_17, 0);
        bus(1'b0, KIND_SKIP, FN_04, 0);
        check(rd, 32'h1);
        bus(1'b1, KIND_OUTPUT, FN_04, 32'h8004);
        bus(1'b1, KIND_OUTPUT, FN_05, 32'h2);
        bus(1'b1, KIND_OUTPUT, FN_14, 32'h1);
        u_term.send(8'h77);
        for (i = 0; i < 400 && dma_rx.req !== 1'b1; i++) @(posedge pclk);
        guard(i, 400);
        check(dma_rx.data, 8'h77);
        dma_rx_ack <= 1'b1;
        @(posedge pclk);
        dma_rx_ack <= 1'b0;
        bus(1'b0, KIND_SKIP, FN_02, 0);
        check(irq_req, 1'b1);
        bus(1'b1, KIND_OUTPUT, FN_16, 32'h1234);
        bus(1'b1, KIND_OUTPUT, FN_05, 32'h6);
        @(posedge pclk);
        check(ivec, 16'h1234);
        check(irq_req, 1'b0);
        ce  <= 1'b0;
        ica <= 1'b1;
        repeat (2) @(posedge pclk);
        check(irq_req, 1'b0);
        ce  <= 1'b1;
        @(posedge pclk);
        ica <= 1'b0;
        @(posedge pclk);
        check(irq_req, 1'b1);
        end_of_test();
    end
endmodule : aspic_bench

/* tb/aspic_chk.sv */
// pin-level assertion checker for the serial port command block
`timescale 1ns/1ps
module aspic_chk
    import aspic_pkg::*;
(
    input wire logic          pclk,
    input wire logic          presetn,
    input wire logic          psel,
    input wire logic          penable,
    input wire logic          pwrite,
    input wire logic [15:0]   paddr,
    input wire logic [31:0]   prdata,
    input wire logic          pready,
    input wire logic          pslverr,
    input wire logic          irq_req,
    input wire aspic_dma_type dma_rx,
    input wire logic          dma_rx_ack
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       acc, ok, rd;
    logic [1:0] kd;
    logic [3:0] fn;
    assign acc = psel && penable && pready;
    assign ok  = paddr[7:2] == DEV_ADDR;
    assign kd  = paddr[13:12];
    assign fn  = paddr[11:8];
    assign rd  = acc && !pwrite && ok;
    AST_BAD_DEV: assert property (acc && !ok |-> pslverr)
        else $error("foreign device address accepted");
    AST_ONE_WAIT: assert property (psel && $rose(penable)
        |-> !pready ##1 pready) else $error("access wait not one cycle");
    AST_PULSE: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    AST_SKIP_BIN: assert property (rd && kd == KIND_SKIP
        |-> prdata[31:1] == 31'h0) else $error("skip answer not one bit");
    AST_IN_CHAR: assert property (rd && kd == KIND_INPUT
        && (fn == FN_00 || fn == FN_10) |-> prdata[30:8] == 23'h0
        && (prdata[31] || prdata[7:0] == 8'h00)) else $error("bad char read");
    AST_IN_WORD: assert property (rd && kd == KIND_INPUT && fn == FN_04
        |-> prdata[31:16] == 16'h0) else $error("control word read too wide");
    AST_INIT: assert property (acc && pwrite && ok && kd == KIND_CONTROL
        && fn == FN_17 |-> ##[1:3] !irq_req) else $error("irq after init");
    AST_DMA_DROP: assert property (dma_rx.req && dma_rx_ack
        |=> !dma_rx.req) else $error("dma request held after ack");
    AST_DMA_HOLD: assert property (dma_rx.req && !dma_rx_ack && !acc
        |=> dma_rx.req && $stable(dma_rx.data)) else $error("dma req unstable");
    cover property (rd && kd == KIND_INPUT && prdata[31]);
    cover property (dma_rx.req && dma_rx_ack);
    cover property ($rose(irq_req));
endmodule : aspic_chk

bind aspic_top aspic_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq_req(irq_req), .dma_rx(dma_rx),
    .dma_rx_ack(dma_rx_ack));

/* tb/aspic_term.sv */
// serial terminal model on one port of the block
`timescale 1ns/1ps
module aspic_term #(
    parameter int BIT  = 5,
    parameter int PORT = 2
) (
    input  wire logic       pclk,
    input  wire logic [3:0] tx_line,
    output logic      [3:0] rx_line
);
    logic [7:0] got;
    int         n_got = 0;
    initial rx_line = 4'hF; // lines idle marking
    task automatic send(input logic [7:0] c);
        logic [9:0] f;
        f = {1'b1, c, 1'b0}; // start, lsb first, stop
        for (int i = 0; i < 10; i++) begin
            rx_line[PORT] <= f[i];
            repeat (BIT) @(posedge pclk);
        end
    endtask : send
    always begin
        @(negedge tx_line[PORT]);
        repeat (BIT / 2 + BIT) @(posedge pclk);
        for (int i = 0; i < 8; i++) begin
            got[i] = tx_line[PORT];
            repeat (BIT) @(posedge pclk);
        end
        n_got++;
    end
endmodule : aspic_term
